// ==== entropy_map.svh ====
`ifndef ENTROPY_MAP_SVH
`define ENTROPY_MAP_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define RO_COUNT         4
`define SAMPLE_W         4
`define WORD_W           32
`define FIFO_DEPTH       8
`define FIFO_AW          3

// ------------------------------------------------------------
// sampling and monitor timing, in sys_clk cycles
// ------------------------------------------------------------
`define SAMPLE_DIV_LAST  8'h0f
`define STALL_LIMIT      8'hff

// ------------------------------------------------------------
// test sizes and fixed cutoffs
// ------------------------------------------------------------
`define STARTUP_LAST     11'h3ff
`define APT_LAST         9'h1ff
`define RCT_CUTOFF       6'h20
`define APT_CUTOFF       10'h0c0
`define FAIL_LIMIT       2'h3
`define WORD_LAST        3'h7

`endif

// ==== entropy_pkg.sv ====
`include "entropy_map.svh"

package entropy_pkg;

	typedef logic [`SAMPLE_W-1:0] sample_t;
	typedef logic [`WORD_W-1:0]   word_t;

	typedef enum logic [1:0] {
		ST_RESTART,
		ST_STARTUP,
		ST_RUN,
		ST_PERM
	} ctl_state_t;

	typedef struct packed {
		logic  valid;
		word_t data;
	} fetch_rsp_t;

	typedef struct packed {
		logic       startup_ok;
		logic       perm_fail;
		logic [1:0] fail_count;
	} health_status_t;

endpackage

// ==== health_tests.sv ====
`include "entropy_map.svh"

module health_tests
	import entropy_pkg::*;
(
	// clock and reset
	input  wire logic    sys_clk,
	input  wire logic    resetn,
	// sample stream
	input  wire logic    clear,
	input  wire logic    sample_valid,
	input  wire sample_t sample,
	// result
	output logic         fail
);

	sample_t    rct_last;
	logic [5:0] rct_run;
	sample_t    apt_ref;
	logic [8:0] apt_idx;
	logic [9:0] apt_match;

	// ------------------------------------------------------------
	// repetition count
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn || clear) begin
			rct_last <= '0;
			rct_run  <= '0;
		end else if (sample_valid) begin
			rct_last <= sample;
			if (sample == rct_last && rct_run != '0)
				rct_run <= rct_run + 6'h01;
			else
				rct_run <= 6'h01;
		end
	end

	// ------------------------------------------------------------
	// adaptive proportion
	// ------------------------------------------------------------
	// fixed 512 window
	always_ff @(posedge sys_clk) begin
		if (!resetn || clear) begin
			apt_ref   <= '0;
			apt_idx   <= '0;
			apt_match <= '0;
		end else if (sample_valid) begin
			apt_idx <= (apt_idx == `APT_LAST) ? 9'h000 : apt_idx + 9'h001;
			if (apt_idx == 9'h000) begin
				apt_ref   <= sample;
				apt_match <= 10'h001;
			end else if (sample == apt_ref) begin
				apt_match <= apt_match + 10'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// verdict
	// ------------------------------------------------------------
	// fixed cutoffs fail
	always_ff @(posedge sys_clk) begin
		if (!resetn || clear)
			fail <= 1'b0;
		else
			fail <= (rct_run >= `RCT_CUTOFF) || (apt_match >= `APT_CUTOFF);
	end

endmodule

// ==== entropy_source_health_control.sv ====
`include "entropy_map.svh"

module entropy_source_health_control
	import entropy_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// ring oscillator outputs, asynchronous
	input  wire logic [`RO_COUNT-1:0] ring_oscillators,
	// entropy_fetch_port to the generator
	input  wire logic                 fetch_ready,
	output fetch_rsp_t                fetch_rsp,
	// health state
	output health_status_t            status
);

	logic [`RO_COUNT-1:0] ro_meta;
	logic [`RO_COUNT-1:0] ro_sync;
	logic [`RO_COUNT-1:0] ro_prev;
	logic [`RO_COUNT-1:0] ro_stalled;
	logic [7:0]           div_cnt;
	logic                 samp_valid;
	sample_t              samp;
	logic                 stat_fail;
	logic                 osc_fail;
	logic                 any_fail;
	logic                 active;
	logic                 flush;
	ctl_state_t           state;
	logic [1:0]           fail_count;
	logic [10:0]          start_cnt;
	word_t                acc;
	logic [2:0]           acc_cnt;
	word_t                mem [`FIFO_DEPTH];
	logic [`FIFO_AW:0]    wr_ptr;
	logic [`FIFO_AW:0]    rd_ptr;
	logic                 fifo_empty;
	logic                 fifo_full;
	logic                 push;
	logic                 pop;

	// shared by the state machine and the status flags
	function automatic logic last_strike(logic [1:0] count);
		return count == `FAIL_LIMIT - 2'h1;
	endfunction

	// ------------------------------------------------------------
	// oscillator synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ro_meta <= '0;
			ro_sync <= '0;
			ro_prev <= '0;
		end else begin
			ro_meta <= ring_oscillators;
			ro_sync <= ro_meta;
			ro_prev <= ro_sync;
		end
	end

	// ------------------------------------------------------------
	// noise sampler
	// ------------------------------------------------------------
	// slow fixed rate so oscillator jitter accumulates between samples
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			div_cnt    <= '0;
			samp_valid <= 1'b0;
			samp       <= '0;
		end else begin
			div_cnt    <= (div_cnt == `SAMPLE_DIV_LAST) ? 8'h00
			              : div_cnt + 8'h01;
			samp_valid <= (div_cnt == `SAMPLE_DIV_LAST);
			if (div_cnt == `SAMPLE_DIV_LAST)
				samp <= ro_sync;
		end
	end

	assign active = (state == ST_STARTUP) || (state == ST_RUN);
	assign flush  = (state == ST_RESTART) || (state == ST_PERM);

	// ------------------------------------------------------------
	// statistical tests
	// ------------------------------------------------------------
	// tests on every sample taken in start-up and run
	health_tests u_health (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.clear        (flush),
		.sample_valid (samp_valid && active),
		.sample       (samp),
		.fail         (stat_fail)
	);

	// ------------------------------------------------------------
	// oscillator monitor
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RO_COUNT; gi++) begin : g_osc
			logic [7:0] idle;
			always_ff @(posedge sys_clk) begin
				if (!resetn || ro_sync[gi] != ro_prev[gi]) begin
					idle <= '0;
				end else if (idle != `STALL_LIMIT) begin
					idle <= idle + 8'h01;
				end
			end
			assign ro_stalled[gi] = (idle == `STALL_LIMIT);
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			osc_fail <= 1'b0;
		else
			osc_fail <= |ro_stalled;
	end

	assign any_fail = active && (stat_fail || osc_fail);

	// ------------------------------------------------------------
	// failure control
	// ------------------------------------------------------------
	// reset lands in restart
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= ST_RESTART;
		end else begin
			case (state)
				ST_RESTART: state <= ST_STARTUP;
				ST_STARTUP: begin
					if (any_fail)
						state <= last_strike(fail_count)
						         ? ST_PERM : ST_RESTART;
					else if (samp_valid && start_cnt == `STARTUP_LAST)
						state <= ST_RUN;
				end
				ST_RUN: begin
					if (any_fail)
						state <= last_strike(fail_count)
						         ? ST_PERM : ST_RESTART;
				end
				ST_PERM:    state <= ST_PERM;
				default:    state <= ST_RESTART;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			fail_count <= '0;
		else if (any_fail && fail_count != `FAIL_LIMIT)
			fail_count <= fail_count + 2'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || state != ST_STARTUP)
			start_cnt <= '0;
		else if (samp_valid)
			start_cnt <= start_cnt + 11'h001;
	end

	// ------------------------------------------------------------
	// accumulator
	// ------------------------------------------------------------
	// raw bits, no conditioning
	always_ff @(posedge sys_clk) begin
		if (!resetn || flush) begin
			acc     <= '0;
			acc_cnt <= '0;
		end else if (samp_valid && active) begin
			acc     <= {acc[`WORD_W-`SAMPLE_W-1:0], samp};
			acc_cnt <= acc_cnt + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// entropy fifo
	// ------------------------------------------------------------
	// a full fifo drops fresh words; the source cannot be stalled
	assign fifo_empty = (wr_ptr == rd_ptr);
	assign fifo_full  = (wr_ptr[`FIFO_AW] != rd_ptr[`FIFO_AW]) &&
	                    (wr_ptr[`FIFO_AW-1:0] == rd_ptr[`FIFO_AW-1:0]);
	assign push = samp_valid && active && !any_fail &&
	              acc_cnt == `WORD_LAST && !fifo_full;
	assign pop  = (state == ST_RUN) && !any_fail && !fifo_empty &&
	              (!fetch_rsp.valid || fetch_ready);

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr[`FIFO_AW-1:0]] <=
				{acc[`WORD_W-`SAMPLE_W-1:0], samp};
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || flush || any_fail) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 4'h1;
			if (pop)
				rd_ptr <= rd_ptr + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// entropy_fetch_port
	// ------------------------------------------------------------
	// single generator port
	always_ff @(posedge sys_clk) begin
		if (!resetn || state != ST_RUN || any_fail) begin
			fetch_rsp <= '0;
		end else if (pop) begin
			fetch_rsp.valid <= 1'b1;
			fetch_rsp.data  <= mem[rd_ptr[`FIFO_AW-1:0]];
		end else if (fetch_ready) begin
			fetch_rsp.valid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// status
	// ------------------------------------------------------------
	// status only, nothing configurable
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			status <= '0;
		end else begin
			status.startup_ok <= (state == ST_RUN) && !any_fail;
			status.perm_fail  <= (state == ST_PERM) ||
			                     (any_fail && last_strike(fail_count));
			status.fail_count <= (any_fail && fail_count != `FAIL_LIMIT)
			                     ? fail_count + 2'h1 : fail_count;
		end
	end

endmodule

// ==== entropy_consumer.sv ====
`include "entropy_map.svh"

module entropy_consumer
	import entropy_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// entropy_fetch_port
	input  wire fetch_rsp_t fetch_rsp,
	input  wire logic       slow,
	output logic            fetch_ready,
	// words accepted
	output logic [15:0]     words
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] phase = 2'h0;

	// slow mode takes one cycle in four, so words stand a while
	assign fetch_ready = !slow || phase == 2'h3;

	always_ff @(posedge sys_clk) begin
		phase <= phase + 2'h1;
		if (!resetn)
			words <= 16'h0;
		else if (fetch_rsp.valid && fetch_ready)
			words <= words + 16'h1;
	end
endmodule

// ==== health_ctl_assertions.sv ====
`include "entropy_map.svh"

module health_ctl_assertions
	import entropy_pkg::*;
(
	// watched ports
	input wire logic                 sys_clk,
	input wire logic                 resetn,
	input wire logic [`RO_COUNT-1:0] ring_oscillators,
	input wire logic                 fetch_ready,
	input wire fetch_rsp_t           fetch_rsp,
	input wire health_status_t       status
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [8:0]           still [`RO_COUNT];
	logic [`RO_COUNT-1:0] ro_q;
	logic [1:0]           fc_q;
	logic [14:0]          wait_cyc;
	logic                 stalled;

	// margin over the stall limit covers synchronisers
	always_comb begin
		stalled = 1'b0;
		for (int i = 0; i < `RO_COUNT; i++)
			if (still[i] >= 9'h118)
				stalled = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		ro_q <= ring_oscillators;
		for (int i = 0; i < `RO_COUNT; i++)
			if (!resetn || ro_q[i] != ring_oscillators[i])
				still[i] <= 9'h0;
			else if (still[i] != 9'h1ff)
				still[i] <= still[i] + 9'h1;
	end

	always_ff @(posedge sys_clk) begin
		fc_q <= status.fail_count;
		if (!resetn || status.startup_ok || fc_q != status.fail_count)
			wait_cyc <= 15'h0;
		else if (wait_cyc != 15'h7fff)
			wait_cyc <= wait_cyc + 15'h1;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_no_early_words: assert property (
		fetch_rsp.valid |-> status.startup_ok)
		else $error("word offered outside normal operation");
	a_perm_holds: assert property (
		status.perm_fail |=> status.perm_fail)
		else $error("permanent failure left without reset");
	a_perm_silent: assert property (
		status.perm_fail |-> !fetch_rsp.valid && !status.startup_ok)
		else $error("entropy offered in permanent failure");
	a_perm_third: assert property (
		$rose(status.perm_fail) |-> status.fail_count == `FAIL_LIMIT)
		else $error("permanent failure at wrong count");
	a_count_steps: assert property (
		status.fail_count != $past(status.fail_count)
		|-> status.fail_count == $past(status.fail_count) + 2'h1)
		else $error("failure count moved other than by one");
	a_fail_restarts: assert property (
		status.fail_count != $past(status.fail_count)
		|-> !status.startup_ok && !fetch_rsp.valid)
		else $error("no restart after failure");
	a_word_stands: assert property (
		fetch_rsp.valid && !fetch_ready
		|=> !status.startup_ok || (fetch_rsp.valid && $stable(fetch_rsp.data)))
		else $error("offered word changed before taken");
	a_stall_fails: assert property (
		stalled |-> !status.startup_ok)
		else $error("stopped oscillator not reported");
	a_startup_len: assert property (
		$rose(status.startup_ok) |-> wait_cyc >= 15'h3f00)
		else $error("start-up passed too early");

	c_startup: cover property ($rose(status.startup_ok));
	c_taken: cover property (fetch_rsp.valid && fetch_ready);
	c_perm: cover property ($rose(status.perm_fail));
endmodule

bind entropy_source_health_control health_ctl_assertions chk (
	.sys_clk          (sys_clk),
	.resetn           (resetn),
	.ring_oscillators (ring_oscillators),
	.fetch_ready      (fetch_ready),
	.fetch_rsp        (fetch_rsp),
	.status           (status)
);

// ==== tb.sv ====
`include "entropy_map.svh"

module tb
	import entropy_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 sys_clk = 1'b0;
	logic                 resetn = 1'b0;
	logic [`RO_COUNT-1:0] ro = 4'h0;
	logic [`RO_COUNT-1:0] stall_mask = 4'h0;
	logic [1:0]           mode = 2'h0;
	logic                 slow = 1'b0;
	logic                 fetch_ready;
	fetch_rsp_t           fetch_rsp;
	health_status_t       status;
	logic [15:0]          words;
	logic [15:0]          w0;
	logic [1:0]           exp_q[$];
	logic [1:0]           last_fc;
	logic [3:0]           tick = 4'h0;
	logic [8:0]           in_alt = 9'h0;
	logic [27:0]          nib_diff;
	int                   error_cnt = 0;
	int                   n_compared = 0;
	integer               seed = 32'ha946;

	entropy_source_health_control uut (
		.sys_clk          (sys_clk),
		.resetn           (resetn),
		.ring_oscillators (ro),
		.fetch_ready      (fetch_ready),
		.fetch_rsp        (fetch_rsp),
		.status           (status)
	);
	entropy_consumer gen (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.fetch_rsp   (fetch_rsp),
		.slow        (slow),
		.fetch_ready (fetch_ready),
		.words       (words)
	);

	initial forever #2.5 sys_clk = ~sys_clk;

	// mode 1 toggles every cycle: sampled every 16, so samples repeat
	// mode 3 toggles every 16 cycles, so samples alternate
	always @(posedge sys_clk) begin
		tick   <= tick + 4'h1;
		in_alt <= (mode != 2'h3) ? 9'h0 : in_alt + 9'(in_alt != 9'h1ff);
		case (mode)
			2'h0: ro <= 4'($random(seed));
			2'h1: ro <= ~ro;
			2'h3: ro <= (tick == 4'h0) ? ~ro : ro;
			default: ro <= (4'($random(seed)) & ~stall_mask) | (ro & stall_mask);
		endcase
	end

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic await(bit want_ok, int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge sys_clk);
			if (want_ok ? status.startup_ok === 1'b1 : exp_q.size() == 0)
				return;
		end
		error_cnt++;
		$display("wrong value wait expected event seen timeout");
		conclude();
	endtask

	// a stuck oscillator keeps failing each start-up, so counts can chain
	task automatic fail_by(logic [1:0] m, logic [3:0] mask, int lo, int hi,
	                       int lim);
		for (int c = lo; c <= hi; c++)
			exp_q.push_back(2'(c));
		stall_mask <= mask;
		mode <= m;
		await(1'b0, lim);
		mode <= 2'h0;
		stall_mask <= 4'h0;
		repeat (300) @(posedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// failure count watcher
	// ------------------------------------------------------------
	always @(posedge sys_clk)
		if (!resetn)
			last_fc <= 2'h0;
		else if (status.fail_count !== last_fc) begin
			last_fc <= status.fail_count;
			check("fail_count", exp_q.size() ? exp_q.pop_front() : 2'hx,
				status.fail_count);
		end

	// ------------------------------------------------------------
	// word content watcher
	// ------------------------------------------------------------
	// raw words from mode 3 pair each nibble with its inverse
	assign nib_diff = fetch_rsp.data[31:4] ^ fetch_rsp.data[27:0];

	always @(posedge sys_clk)
		if (in_alt == 9'h1ff && fetch_rsp.valid && fetch_ready)
			check("word pattern", 32'h0fffffff, 32'(nib_diff));

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		await(1'b1, 20000);
		check("status", 32'h8, 32'(status));
		repeat (600) @(posedge sys_clk);
		check("words taken", 32'h1, 32'(words != 16'h0));
		slow <= 1'b1;
		repeat (600) @(posedge sys_clk);
		$display("test startup done");
		// repeated samples trip the repetition count once
		fail_by(2'h1, 4'h0, 1, 1, 1200);
		await(1'b1, 20000);
		check("status", 32'h9, 32'(status));
		$display("test restart done");
		// stuck oscillator fails in run, then again in start-up
		fail_by(2'h2, 4'h8, 2, 3, 1200);
		w0 = words;
		repeat (2000) @(posedge sys_clk);
		check("status", 32'h7, 32'(status));
		check("words in perm", 32'(w0), 32'(words));
		$display("test permanent done");
		resetn <= 1'b0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check("status", 32'h0, 32'(status));
		await(1'b1, 20000);
		// alternating samples trip the proportion test
		fail_by(2'h3, 4'h0, 1, 1, 15000);
		await(1'b1, 20000);
		check("status", 32'h9, 32'(status));
		fail_by(2'h2, 4'h1, 2, 3, 1200);
		check("status", 32'h7, 32'(status));
		$display("test reset done");
		conclude();
	end
endmodule
